// ---- design/kshci_defs.vh ----
// Constants for the key-scan host command interface
`ifndef KSHCI_DEFS_VH
`define KSHCI_DEFS_VH

// ****************************************************************
// Bus address and command codes
// ****************************************************************
`define KSHCI_SLAVE_ADDR      7'h51
`define KSHCI_CMD_QUEUE_READ  8'h20
`define KSHCI_CMD_QUEUE_RPT   8'h21
`define KSHCI_CMD_DEBOUNCE    8'h22
`define KSHCI_CMD_INT_READ    8'hD0
`define KSHCI_CMD_PIN_EDGE    8'hD1
`define KSHCI_CMD_STAT_READ   8'hE0
`define KSHCI_CMD_ACTIVE      8'hE4
`define KSHCI_CMD_ERR_READ    8'hF0

// ****************************************************************
// Field positions
// ****************************************************************
`define KSHCI_INT_ERR_BIT     3
`define KSHCI_INT_PIN1_BIT    2
`define KSHCI_INT_PIN0_BIT    1
`define KSHCI_INT_KEY_BIT     0
`define KSHCI_ERR_QOVR_BIT    6
`define KSHCI_ERR_LOST_BIT    4
`define KSHCI_ERR_KEYS_BIT    2
`define KSHCI_ERR_UNK_BIT     1
`define KSHCI_ERR_EARLY_BIT   0

// ****************************************************************
// Reset and code values
// ****************************************************************
`define KSHCI_STAT_RESET      8'h00
`define KSHCI_STAT_WAKE       8'h02
`define KSHCI_STAT_ACK        8'h06
`define KSHCI_STAT_NOACK      8'h15
`define KSHCI_EMPTY_CODE      8'h00
`define KSHCI_QUEUE_DEPTH     4'hE

// ****************************************************************
// Timing
// ****************************************************************
`define KSHCI_CLK_MHZ         200
`define KSHCI_DEBOUNCE_MS     10
`define KSHCI_ACTIVE_MS       500
`define KSHCI_STEP_MS         4
`define KSHCI_STRETCH_NS      250
`define KSHCI_DEBOUNCE_RESET  ((`KSHCI_DEBOUNCE_MS * 2 + `KSHCI_STEP_MS) / (`KSHCI_STEP_MS * 2))
`define KSHCI_ACTIVE_RESET    ((`KSHCI_ACTIVE_MS * 2 + `KSHCI_STEP_MS) / (`KSHCI_STEP_MS * 2))
`define KSHCI_STRETCH_CYC     ((`KSHCI_STRETCH_NS * `KSHCI_CLK_MHZ + 999) / 1000)

`endif

// ---- design/kshci_sync.v ----
// Two-stage synchroniser for the asynchronous pins
`timescale 1ns/1ps
module kshci_sync (
  input  wire       clk,
  input  wire       resetn,
  input  wire [3:0] async_in,
  output reg  [3:0] sync_out
);
  reg [3:0] stage_one;

  // Bus lines idle high, so the chain resets high to avoid false edges
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_one <= 4'hF;
      sync_out  <= 4'hF;
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule // kshci_sync

// ---- design/kshci_top.v ----
// Host command interface: two-wire slave, event queue, codes and settings
//
// Notes on behaviour
// [RULE_01] First byte: address 0x51 plus direction bit
// [RULE_02] Host frames transfers with start and stop
// [RULE_03] Write: address, command byte, then data
// [RULE_04] Read: command, repeated start, address with read
// [RULE_05] Host ends a read with NACK
// [RULE_06] Bus wakes from halt; first address NACKed
// [RULE_07] Retried address is acknowledged once awake
// [RULE_08] START byte wakes device, never acknowledged
// [RULE_09] Device may stretch SCL while busy
// [RULE_10] Interrupt read returns, clears code, releases request
// [RULE_11] Interrupt code: error, pin1, pin0, key bits
// [RULE_12] One pin enabled sets both pin bits
// [RULE_13] Error read returns and clears error byte
// [RULE_14] Overflow, keys, unknown, early, lost set errors
// [RULE_15] Status: reset, wake, success, failure codes
// [RULE_16] Host reads error code when error bit set
// [RULE_17] Queue holds 14 events, ends with 00
// [RULE_18] Repeat read streams queue without popping; the code returns the oldest event on every byte
// [RULE_19] New key event pulls request low
// [RULE_20] Enabled pin edge wakes and requests attention
// [RULE_21] Debounce default 10 ms, set by 0x22
// [RULE_22] Active default 500 ms, above debounce
// [RULE_23] Event code MSB: 1 pressed, 0 released
// [RULE_24] Pin edge command has one enable per pin
`timescale 1ns/1ps
`include "kshci_defs.vh"
module kshci_top (
  input  wire       clk,
  input  wire       resetn,
  input  wire       scl_in,
  input  wire       sda_in,
  input  wire       aux_pin_zero,
  input  wire       aux_pin_one,
  input  wire       key_event_valid,
  input  wire       key_pressed,
  input  wire [6:0] key_index,
  input  wire       key_overrun,
  input  wire       irq_withdrawn,
  input  wire       halt_request,
  output reg        sda_out,
  output reg        sda_oe,
  output reg        scl_out,
  output reg        scl_oe,
  output reg        irq_n,
  output reg        awake,
  output reg  [7:0] debounce_code,
  output reg  [7:0] active_code,
  output reg  [1:0] pin_edge_enable
);

  // ****************************************************************
  // States and constants
  // ****************************************************************
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_RX    = 6'h02;
  localparam [5:0] S_RXACK = 6'h04;
  localparam [5:0] S_TX    = 6'h08;
  localparam [5:0] S_TXACK = 6'h10;
  localparam [5:0] S_SKIP  = 6'h20;
  localparam integer DEB_FULL    = `KSHCI_DEBOUNCE_RESET;
  localparam integer ACT_FULL    = `KSHCI_ACTIVE_RESET;
  localparam integer STR_FULL    = `KSHCI_STRETCH_CYC;
  localparam [7:0]   DEB_RESET   = DEB_FULL[7:0];
  localparam [7:0]   ACT_RESET   = ACT_FULL[7:0];
  localparam [6:0]   STRETCH_CYC = STR_FULL[6:0];

  // Command class: 0 unknown, 1 write with data, 2 read
  function [1:0] cmd_kind;
    input [7:0] code;
    begin
      case (code)
        `KSHCI_CMD_DEBOUNCE, `KSHCI_CMD_PIN_EDGE, `KSHCI_CMD_ACTIVE: cmd_kind = 2'd1;
        `KSHCI_CMD_QUEUE_READ, `KSHCI_CMD_QUEUE_RPT, `KSHCI_CMD_INT_READ,
        `KSHCI_CMD_STAT_READ, `KSHCI_CMD_ERR_READ: cmd_kind = 2'd2;
        default: cmd_kind = 2'd0;
      endcase
    end
  endfunction

  // ****************************************************************
  // Pin sampling and bus conditions
  // ****************************************************************
  wire [3:0] pins_s;
  reg        prev_scl;
  reg        prev_sda;
  reg  [1:0] prev_pin;

  kshci_sync u_sync (
    .clk      (clk),
    .resetn   (resetn),
    .async_in ({aux_pin_one, aux_pin_zero, sda_in, scl_in}),
    .sync_out (pins_s)
  );

  wire scl_s    = pins_s[0];
  wire sda_s    = pins_s[1];
  wire scl_rise = scl_s & ~prev_scl;
  wire scl_fall = ~scl_s & prev_scl;
  wire start_c  = scl_s & prev_scl & prev_sda & ~sda_s; // RULE_02
  wire stop_c   = scl_s & prev_scl & ~prev_sda & sda_s; // RULE_02
  wire [1:0] pin_edge = pins_s[3:2] ^ prev_pin;

  // ****************************************************************
  // Slave state
  // ****************************************************************
  reg  [5:0] state;
  reg  [7:0] sh;
  reg  [2:0] cnt;
  reg        full;
  reg  [1:0] idx;
  reg        rd_mode;
  reg        host_ack;
  reg  [7:0] cmd;
  reg  [6:0] stretch;
  reg        wake_nack;
  reg  [3:0] int_code;
  reg  [7:0] err_code;
  reg  [7:0] status;
  reg  [7:0] queue [0:13];
  reg  [3:0] wr_ptr;
  reg  [3:0] rd_ptr;
  reg  [3:0] count;

  wire byte_end  = (state == S_RX) & scl_fall & full;
  wire addr_end  = byte_end & (idx == 2'd0);
  wire addr_hit  = (sh[7:1] == `KSHCI_SLAVE_ADDR); // RULE_01
  wire addr_ok   = addr_hit & ~wake_nack; // RULE_06 RULE_07
  wire cmd_end   = byte_end & (idx == 2'd1);
  wire [1:0] kind = cmd_kind(sh);
  wire data_end  = byte_end & (idx == 2'd2);
  wire rd_load   = ((state == S_RXACK) & scl_fall & rd_mode) |
                   ((state == S_TXACK) & scl_fall & host_ack);

  // ****************************************************************
  // Event sources
  // ****************************************************************
  wire q_pop     = rd_load & (cmd == `KSHCI_CMD_QUEUE_READ) & (count != 4'h0); // RULE_18
  wire q_full    = (count == `KSHCI_QUEUE_DEPTH);
  wire q_push    = key_event_valid & (~q_full | q_pop);
  wire q_ovf     = key_event_valid & q_full & ~q_pop; // RULE_14
  wire [1:0] pin_hit = pin_edge & pin_edge_enable; // RULE_20
  wire both_en   = &pin_edge_enable;
  wire pin0_flag = both_en ? pin_hit[0] : |pin_hit; // RULE_12
  wire pin1_flag = both_en ? pin_hit[1] : |pin_hit; // RULE_12
  wire unk_cmd   = cmd_end & (kind == 2'd0);
  wire early_cmd = addr_end & addr_hit & wake_nack;
  wire deb_ok    = (sh != 8'h00);
  wire act_ok    = (sh > debounce_code); // RULE_22
  wire wr_fail   = data_end & (((cmd == `KSHCI_CMD_DEBOUNCE) & ~deb_ok) |
                               ((cmd == `KSHCI_CMD_ACTIVE) & ~act_ok));
  wire clr_int   = rd_load & (cmd == `KSHCI_CMD_INT_READ);
  wire clr_err   = rd_load & (cmd == `KSHCI_CMD_ERR_READ);

  reg [7:0] err_set;
  reg [3:0] int_set;
  reg [7:0] next_err;
  reg [3:0] next_int;
  reg [7:0] rd_byte;

  // Set always wins over a clear in the same cycle
  always @* begin
    err_set = 8'h00;
    err_set[`KSHCI_ERR_QOVR_BIT]  = q_ovf; // RULE_14
    err_set[`KSHCI_ERR_LOST_BIT]  = irq_withdrawn; // RULE_14
    err_set[`KSHCI_ERR_KEYS_BIT]  = key_overrun; // RULE_14
    err_set[`KSHCI_ERR_UNK_BIT]   = unk_cmd; // RULE_14
    err_set[`KSHCI_ERR_EARLY_BIT] = early_cmd; // RULE_14
    next_err = (clr_err ? 8'h00 : err_code) | err_set; // RULE_13
    int_set = 4'h0;
    int_set[`KSHCI_INT_ERR_BIT]  = |err_set; // RULE_11
    int_set[`KSHCI_INT_PIN1_BIT] = pin1_flag; // RULE_11
    int_set[`KSHCI_INT_PIN0_BIT] = pin0_flag; // RULE_11
    int_set[`KSHCI_INT_KEY_BIT]  = q_push; // RULE_19
    next_int = (clr_int ? 4'h0 : int_code) | int_set; // RULE_10
  end

  // Read data chosen by the command that preceded the repeated start
  always @* begin
    case (cmd)
      `KSHCI_CMD_INT_READ:  rd_byte = {4'h0, int_code}; // RULE_10 RULE_11
      `KSHCI_CMD_ERR_READ:  rd_byte = err_code; // RULE_13
      `KSHCI_CMD_STAT_READ: rd_byte = status; // RULE_15
      `KSHCI_CMD_QUEUE_READ, `KSHCI_CMD_QUEUE_RPT: begin
        // Past the last stored event the empty code marks the end
        rd_byte = (count != 4'h0) ? queue[rd_ptr] : `KSHCI_EMPTY_CODE; // RULE_17
      end
      default: rd_byte = `KSHCI_EMPTY_CODE;
    endcase
  end

  // ****************************************************************
  // Two-wire slave engine
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state     <= S_IDLE;
      sh        <= 8'h00;
      cnt       <= 3'h0;
      full      <= 1'b0;
      idx       <= 2'h0;
      rd_mode   <= 1'b0;
      host_ack  <= 1'b0;
      cmd       <= 8'h00;
      sda_oe    <= 1'b0;
      sda_out   <= 1'b0;
      scl_oe    <= 1'b0;
      scl_out   <= 1'b0;
      stretch   <= 7'h00;
      prev_scl  <= 1'b1;
      prev_sda  <= 1'b1;
    end else begin
      prev_scl <= scl_s;
      prev_sda <= sda_s;
      sda_out  <= 1'b0;
      scl_out  <= 1'b0;
      // Stretch ends on its own count; the host just waits on SCL
      if (stretch != 7'h00) begin
        stretch <= stretch - 7'h01;
      end else begin
        scl_oe <= 1'b0;
      end
      if (start_c) begin // RULE_02 RULE_04
        state  <= S_RX;
        cnt    <= 3'h0;
        full   <= 1'b0;
        idx    <= 2'h0;
        sda_oe <= 1'b0;
      end else if (stop_c) begin // RULE_02
        state   <= S_IDLE;
        sda_oe  <= 1'b0;
        rd_mode <= 1'b0;
      end else begin
        case (state)
          S_RX: begin
            if (scl_rise) begin
              sh   <= {sh[6:0], sda_s};
              cnt  <= cnt + 3'h1;
              full <= (cnt == 3'h7);
            end else if (byte_end) begin
              full <= 1'b0;
              if (idx == 2'd0) begin
                // START byte or foreign address is never acknowledged
                if (addr_ok) begin // RULE_01 RULE_07 RULE_08
                  state   <= S_RXACK;
                  sda_oe  <= 1'b1;
                  rd_mode <= sh[0]; // RULE_04
                  idx     <= 2'd1;
                end else begin
                  state <= S_SKIP; // RULE_06
                end
              end else if (idx == 2'd1) begin
                cmd <= sh; // RULE_03
                if (kind == 2'd0) begin
                  state <= S_SKIP;
                end else begin
                  state  <= S_RXACK;
                  sda_oe <= 1'b1;
                  idx    <= 2'd2;
                end
              end else begin
                // Extra data bytes are acknowledged and dropped
                state  <= S_RXACK;
                sda_oe <= 1'b1;
                idx    <= 2'd3; // RULE_03
              end
            end
          end
          S_RXACK: begin
            if (scl_fall) begin
              cnt <= 3'h0;
              if (rd_mode) begin
                // Hold SCL low while the first read byte settles
                state   <= S_TX;
                sh      <= rd_byte;
                sda_oe  <= ~rd_byte[7];
                scl_oe  <= 1'b1; // RULE_09
                // Release happens one edge after zero, so load one less
                stretch <= STRETCH_CYC - 7'h01; // RULE_09
              end else begin
                state  <= S_RX;
                sda_oe <= 1'b0;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (cnt == 3'h7) begin
                state  <= S_TXACK;
                sda_oe <= 1'b0;
              end else begin
                sh     <= {sh[6:0], 1'b0};
                sda_oe <= ~sh[6];
                cnt    <= cnt + 3'h1;
              end
            end
          end
          S_TXACK: begin
            if (scl_rise) begin
              host_ack <= ~sda_s;
            end else if (scl_fall) begin
              cnt <= 3'h0;
              if (host_ack) begin
                state  <= S_TX;
                sh     <= rd_byte;
                sda_oe <= ~rd_byte[7];
              end else begin
                state <= S_SKIP; // RULE_05
              end
            end
          end
          S_IDLE, S_SKIP: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state  <= S_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Power state and wake-up
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awake     <= 1'b1;
      wake_nack <= 1'b0;
      prev_pin  <= 2'h0;
    end else begin
      prev_pin <= pins_s[3:2];
      if (!awake && (~sda_s & prev_sda)) begin
        awake     <= 1'b1; // RULE_06 RULE_08
        wake_nack <= 1'b1; // RULE_06
      end else if (!awake && (pin_hit != 2'h0)) begin
        awake <= 1'b1; // RULE_20
      end else if (halt_request) begin
        awake <= 1'b0;
      end
      // Any completed address byte uses up the post-wake refusal
      if (addr_end) begin
        wake_nack <= 1'b0; // RULE_07 RULE_08
      end
    end
  end

  // ****************************************************************
  // Codes, status and settings
  // ****************************************************************
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_code        <= 4'h0;
      err_code        <= 8'h00;
      irq_n           <= 1'b1;
      status          <= `KSHCI_STAT_RESET; // RULE_15
      debounce_code   <= DEB_RESET; // RULE_21
      active_code     <= ACT_RESET; // RULE_22
      pin_edge_enable <= 2'h0;
    end else begin
      int_code <= next_int;
      err_code <= next_err;
      irq_n    <= ~(|next_int); // RULE_10 RULE_19 RULE_20
      if (unk_cmd || wr_fail) begin
        status <= `KSHCI_STAT_NOACK; // RULE_15
      end else if (data_end || (cmd_end && sh != `KSHCI_CMD_STAT_READ)) begin
        status <= `KSHCI_STAT_ACK; // RULE_15
      end else if (!awake && (pin_hit != 2'h0)) begin
        status <= `KSHCI_STAT_WAKE; // RULE_15
      end
      if (data_end) begin
        case (cmd)
          `KSHCI_CMD_DEBOUNCE: begin
            if (deb_ok) begin
              debounce_code <= sh; // RULE_21
            end
          end
          `KSHCI_CMD_ACTIVE: begin
            if (act_ok) begin
              active_code <= sh; // RULE_22
            end
          end
          `KSHCI_CMD_PIN_EDGE: pin_edge_enable <= sh[1:0]; // RULE_24
          default: pin_edge_enable <= pin_edge_enable;
        endcase
      end
    end
  end

  // ****************************************************************
  // Event queue
  // ****************************************************************
  // Storage has no reset; only the pointers and count need one
  always @(posedge clk) begin
    if (q_push) begin
      queue[wr_ptr] <= {key_pressed, key_index}; // RULE_23
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count  <= 4'h0;
    end else begin
      if (q_push) begin
        wr_ptr <= (wr_ptr == 4'hD) ? 4'h0 : wr_ptr + 4'h1; // RULE_17
      end
      if (q_pop) begin
        rd_ptr <= (rd_ptr == 4'hD) ? 4'h0 : rd_ptr + 4'h1; // RULE_17
      end
      if (q_push && !q_pop) begin
        count <= count + 4'h1;
      end else if (q_pop && !q_push) begin
        count <= count - 4'h1;
      end
    end
  end

endmodule // kshci_top

// ---- bench/kshci_top_asserts.sv ----
// Port checker for the host command interface
`timescale 1ns/1ps
module kshci_top_asserts (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       scl_in,
  input wire logic       aux_pin_zero,
  input wire logic       aux_pin_one,
  input wire logic       key_event_valid,
  input wire logic       key_overrun,
  input wire logic       sda_oe,
  input wire logic       scl_oe,
  input wire logic       irq_n,
  input wire logic       awake,
  input wire logic [7:0] debounce_code,
  input wire logic [7:0] active_code,
  input wire logic [1:0] pin_edge_enable
);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [6:0] st_cnt;
  // A counter, since a 50-cycle repetition would crawl
  always @(posedge clk or negedge resetn)
    if (!resetn) st_cnt <= 7'h00;
    else if (scl_oe) st_cnt <= st_cnt + 7'h01;
    else st_cnt <= 7'h00;
  sequence s_pin_edge;
    pin_edge_enable[0] && $changed(aux_pin_zero) || pin_edge_enable[1] && $changed(aux_pin_one);
  endsequence
  sequence s_attn;
    ##[1:10] (awake && !irq_n);
  endsequence
  property p_stretch;
    $fell(scl_oe) |-> st_cnt == 7'h32;
  endproperty
  a_stretch: assert property (p_stretch) else $error("stretch length wrong");
  property p_sda_low;
    $changed(sda_oe) |-> !scl_in && !$past(scl_in);
  endproperty
  a_sda_low: assert property (p_sda_low) else $error("sda moved with scl high");
  property p_key;
    key_event_valid |-> ##[1:3] !irq_n;
  endproperty
  a_key: assert property (p_key) else $error("key event without request");
  property p_pin;
    s_pin_edge |-> s_attn;
  endproperty
  a_pin: assert property (p_pin) else $error("pin edge without wake");
  property p_ovr;
    key_overrun |-> ##[1:3] !irq_n;
  endproperty
  a_ovr: assert property (p_ovr) else $error("overrun without request");
  property p_halt;
    !awake |-> !sda_oe && !scl_oe;
  endproperty
  a_halt: assert property (p_halt) else $error("bus driven in halt");
  property p_irq;
    $rose(irq_n) |-> scl_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("request released off read");
  property p_deb;
    debounce_code != 8'h00;
  endproperty
  a_deb: assert property (p_deb) else $error("debounce zero");
  property p_act;
    active_code > debounce_code;
  endproperty
  a_act: assert property (p_act) else $error("active not above debounce");
endmodule // kshci_top_asserts
bind kshci_top kshci_top_asserts u_kshci_top_asserts (
  .clk, .resetn, .scl_in, .aux_pin_zero, .aux_pin_one, .key_event_valid, .key_overrun,
  .sda_oe, .scl_oe, .irq_n, .awake, .debounce_code, .active_code, .pin_edge_enable
);

// ---- bench/kshci_host_model.sv ----
// Bus master model driving the two-wire pins
`timescale 1ns/1ps
module kshci_host_model (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_lo,
  output logic      sda_lo
);
  // ********
  // Bit timing, about 70 ns a bus clock
  // ********
  initial begin
    scl_lo = 1'b0;
    sda_lo = 1'b0;
  end
  task tk(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Bounded wait on SCL so a stuck stretch cannot hang us here
  task bit_cyc(input logic d, output logic q);
    integer w;
    tk(3);
    sda_lo <= ~d;
    tk(4);
    scl_lo <= 1'b0;
    w = 0;
    tk(1);
    while (scl !== 1'b1 && w < 200) begin
      tk(1);
      w++;
    end
    // A stretch that never ends is a failure, not a silent pass
    if (w >= 200) kshci_tb_top.n_errors++;
    tk(3);
    q = sda;
    tk(3);
    scl_lo <= 1'b1;
  endtask
  task start;
    tk(3);
    sda_lo <= 1'b0;
    tk(4);
    scl_lo <= 1'b0;
    tk(6);
    sda_lo <= 1'b1;
    tk(6);
    scl_lo <= 1'b1;
  endtask
  task stop;
    tk(3);
    sda_lo <= 1'b1;
    tk(4);
    scl_lo <= 1'b0;
    tk(6);
    sda_lo <= 1'b0;
    tk(8);
  endtask
  task write_byte(input logic [7:0] b, output logic ak);
    logic q;
    for (int i = 7; i >= 0; i--) bit_cyc(b[i], q);
    bit_cyc(1'b1, q);
    ak = (q === 1'b0);
  endtask
  task read_byte(input logic last, output logic [7:0] b);
    logic q;
    for (int i = 7; i >= 0; i--) bit_cyc(1'b1, b[i]);
    bit_cyc(last, q);
  endtask
endmodule // kshci_host_model

// ---- bench/kshci_tb_top.sv ----
// Self-checking bench for the host command interface
`timescale 1ns/1ps
module kshci_tb_top;
  logic       clk, resetn, aux_pin_zero, aux_pin_one, key_event_valid, key_pressed;
  logic       key_overrun, irq_withdrawn, halt_request, a, k;
  logic [6:0] key_index;
  logic [7:0] rb [0:15];
  wire        sda_out, sda_oe, scl_out, scl_oe, irq_n, awake, scl_lo, sda_lo;
  wire  [7:0] debounce_code, active_code;
  wire  [1:0] pin_edge_enable;
  integer     n_errors = 0, tests_run = 0, i;
  // Pulled-up lines: low while any party pulls
  wire        scl = ~(scl_lo | (scl_oe & ~scl_out));
  wire        sda = ~(sda_lo | (sda_oe & ~sda_out));
  kshci_top u_kshci_top (
    .clk, .resetn, .scl_in(scl), .sda_in(sda), .aux_pin_zero, .aux_pin_one,
    .key_event_valid, .key_pressed, .key_index, .key_overrun, .irq_withdrawn,
    .halt_request, .sda_out, .sda_oe, .scl_out, .scl_oe, .irq_n, .awake,
    .debounce_code, .active_code, .pin_edge_enable
  );
  kshci_host_model u_kshci_host_model (.clk, .scl, .sda, .scl_lo, .sda_lo);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ********
  // Tasks
  // ********
  task chk(input string nm, input logic [7:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task give_verdict;
    if (n_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task wr(input logic [7:0] c, d, output logic ak);
    u_kshci_host_model.start();
    u_kshci_host_model.write_byte(8'hA2, k);
    u_kshci_host_model.write_byte(c, ak);
    ak = ak & k;
    if (ak) u_kshci_host_model.write_byte(d, k);
    u_kshci_host_model.stop();
  endtask
  task rd(input logic [7:0] c, input integer n);
    u_kshci_host_model.start();
    u_kshci_host_model.write_byte(8'hA2, k);
    u_kshci_host_model.write_byte(c, k);
    u_kshci_host_model.start();
    u_kshci_host_model.write_byte(8'hA3, k);
    for (int j = 0; j < n; j++) u_kshci_host_model.read_byte(j == n - 1, rb[j]);
    u_kshci_host_model.stop();
  endtask
  task rc(input string nm, input logic [7:0] c, e);
    rd(c, 1);
    chk(nm, rb[0], e);
  endtask
  task key(input logic p, input logic [6:0] x);
    @(posedge clk);
    key_event_valid <= 1'b1;
    key_pressed <= p;
    key_index <= x;
    @(posedge clk);
    key_event_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // Also serves as a plain settling delay with m of zero
  task pls(input logic [2:0] m);
    @(posedge clk);
    {halt_request, irq_withdrawn, key_overrun} <= m;
    @(posedge clk);
    {halt_request, irq_withdrawn, key_overrun} <= 3'h0;
    repeat (10) @(posedge clk);
  endtask
  // ********
  // Tests
  // ********
  initial begin
    {aux_pin_zero, aux_pin_one, key_event_valid, key_pressed} = 4'h0;
    {key_overrun, irq_withdrawn, halt_request, resetn} = 4'h0;
    key_index = 7'h00;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    pls(3'h0);
    chk("awake", {7'h00, awake}, 8'h01);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    chk("debounce", debounce_code, 8'h03);
    chk("active", active_code, 8'h7D);
    chk("pin_en", {6'h00, pin_edge_enable}, 8'h00);
    rc("status", 8'hE0, 8'h00);
    u_kshci_host_model.start();
    u_kshci_host_model.write_byte(8'hA4, a);
    u_kshci_host_model.stop();
    chk("foreign", {7'h00, a}, 8'h00);
    wr(8'hD1, 8'h01, a);
    chk("wr_ack", {7'h00, a}, 8'h01);
    chk("pin_en", {6'h00, pin_edge_enable}, 8'h01);
    rc("status", 8'hE0, 8'h06);
    key(1'b1, 7'h05);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    rc("int", 8'hD0, 8'h01);
    chk("irq_n", {7'h00, irq_n}, 8'h01);
    rd(8'h21, 2);
    chk("rpt0", rb[0], 8'h85);
    chk("rpt1", rb[1], 8'h85);
    rd(8'h20, 2);
    chk("q0", rb[0], 8'h85);
    chk("q1", rb[1], 8'h00);
    key(1'b0, 7'h07);
    rc("q", 8'h20, 8'h07);
    rc("int", 8'hD0, 8'h01);
    aux_pin_zero <= 1'b1;
    pls(3'h0);
    chk("irq_n", {7'h00, irq_n}, 8'h00);
    rc("int", 8'hD0, 8'h06);
    wr(8'hD1, 8'h03, a);
    pls(3'h4);
    chk("awake", {7'h00, awake}, 8'h00);
    aux_pin_one <= 1'b1;
    pls(3'h0);
    chk("awake", {7'h00, awake}, 8'h01);
    rc("status", 8'hE0, 8'h02);
    rc("int", 8'hD0, 8'h04);
    wr(8'h30, 8'h00, a);
    chk("unk_ack", {7'h00, a}, 8'h00);
    rc("status", 8'hE0, 8'h15);
    pls(3'h1);
    pls(3'h2);
    for (i = 0; i < 15; i++) key(1'b1, 7'(i + 1));
    rc("int", 8'hD0, 8'h09);
    rc("err", 8'hF0, 8'h56);
    rc("err", 8'hF0, 8'h00);
    rd(8'h20, 15);
    for (i = 0; i < 15; i++) chk("q", rb[i], i < 14 ? 8'(8'h81 + i) : 8'h00);
    wr(8'h22, 8'h05, a);
    chk("debounce", debounce_code, 8'h05);
    wr(8'h22, 8'h00, a);
    rc("status", 8'hE0, 8'h15);
    wr(8'hE4, 8'h05, a);
    chk("active", active_code, 8'h7D);
    wr(8'hE4, 8'h80, a);
    chk("active", active_code, 8'h80);
    pls(3'h4);
    u_kshci_host_model.start();
    u_kshci_host_model.write_byte(8'hA2, a);
    u_kshci_host_model.stop();
    chk("wake_ack", {7'h00, a}, 8'h00);
    chk("awake", {7'h00, awake}, 8'h01);
    wr(8'hD1, 8'h00, a);
    chk("retry", {7'h00, a}, 8'h01);
    rc("err", 8'hF0, 8'h01);
    pls(3'h4);
    u_kshci_host_model.start();
    u_kshci_host_model.write_byte(8'h01, a);
    u_kshci_host_model.stop();
    chk("start_byte", {7'h00, a}, 8'h00);
    wr(8'hD1, 8'h01, a);
    chk("retry", {7'h00, a}, 8'h01);
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule // kshci_tb_top
